// ==== core/qdc_pkg.sv ====
// Package: frame layout, target codes, span codes and reset values
`default_nettype none
package qdc_pkg;
  localparam int FRAME_BITS   = 24;
  localparam int POS_RW       = 23;
  localparam int POS_RSV      = 22;
  localparam int POS_SEL_HI   = 21;
  localparam int POS_SEL_LO   = 19;
  localparam int POS_CH_HI    = 18;
  localparam int POS_CH_LO    = 16;
  localparam int DATA_BITS    = 16;
  localparam int NUM_CH       = 4;
  localparam logic [2:0] SEL_CODE  = 3'h0;
  localparam logic [2:0] SEL_SPAN  = 3'h1;
  localparam logic [2:0] SEL_POWER = 3'h2;
  localparam logic [2:0] SEL_CTRL  = 3'h3;
  localparam logic [2:0] CH_ALL    = 3'h4;
  localparam logic [2:0] FN_NOP    = 3'h0;
  localparam logic [2:0] FN_CFG    = 3'h1;
  localparam logic [2:0] FN_CLEAR  = 3'h4;
  localparam logic [2:0] FN_LOAD   = 3'h5;
  localparam int POS_TSD      = 3;
  localparam int POS_CLAMP    = 2;
  localparam int POS_CLRSEL   = 1;
  localparam int POS_SDO_OFF  = 0;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam logic [2:0] SPAN_RESET = 3'h0;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [2:0] SPAN_P5    = 3'h0;
  localparam logic [2:0] SPAN_P10   = 3'h1;
  localparam logic [2:0] SPAN_P108  = 3'h2;
  localparam logic [2:0] SPAN_B5    = 3'h3;
  localparam logic [2:0] SPAN_B10   = 3'h4;
  localparam logic [2:0] SPAN_B108  = 3'h5;
  localparam logic [15:0] CODE_ZERO_UNI = 16'h0000;
  localparam logic [15:0] CODE_MID      = 16'h8000;
  localparam logic [15:0] CODE_NEG_FS   = 16'h0000;
  localparam logic [4:0] CNT_LAST = 5'h17;
  // Link pins at rest {clock, frame line, data}: clock and frame line high
  localparam logic [2:0] PIN_IDLE = 3'h6;
endpackage : qdc_pkg
`default_nettype wire

// ==== core/qdc_sync.sv ====
// Two-flop synchroniser for the three serial link pins
`default_nettype none
module qdc_sync (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic [2:0] i_async,
  output logic      [2:0] o_sync
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  // First stage only feeds the second
  always_ff @(posedge i_mclk)
  begin
    // Reset to the pins' idle levels, so no false frame or edge follows
    if (!i_resetn)
    begin
      meta_r <= qdc_pkg::PIN_IDLE;
      sync_r <= qdc_pkg::PIN_IDLE;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule : qdc_sync
`default_nettype wire

// ==== core/qdc_decoder.sv ====
// Serial command decoder for a quad voltage-output converter
`default_nettype none
// What this block does
// - Each frame is exactly 24 bits, taken as one word.
// - Bits arrive MSB first: flag first, data bit zero last.
// - Split: 23 flag, 22 reserved, 21-19 select, 18-16 channel, 15-0 data.
// - Select 000 code, 001 span, 010 power, 011 control.
// - Channel codes 0-3 pick A-D; code 4 picks all four.
// - Select 000 writes data into addressed channel code stores.
// - Resolution 16/14/12 takes bits 15-0, 15-2 or 15-4.
// - Select 001 stores low three data bits as span code.
// - Span codes 0-5 mean +5,+10,+10.8,+-5,+-10,+-10.8 volts.
// - Select 011 routes the frame to the control register.
// - Control function 001 stores thermal, clamp, clear-select, output-off.
// - Control function 000 is a no-op; data ignored.
// - Control function 100 triggers clear regardless of data.
// - Control function 101 triggers load regardless of data.
// - Staged code, span and control registers can be written and read back serially.
// - Clear sets all output codes to the clear code.
// - Load copies staged codes into the output codes.
// - Serial output on after reset; clamp on, thermal off.
// - Clear select 0 gives 0 V; 1 gives mid or negative full scale.
module qdc_decoder #(
  parameter int RES_BITS = 16
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_sclk,
  input  wire logic        i_sync_n,
  input  wire logic        i_serial_in_line,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  output logic [63:0]      o_dac_codes,
  output logic [11:0]      o_spans,
  output logic             o_thermal_en,
  output logic             o_clamp_en,
  output logic             o_update
);
  logic [2:0]  pins;
  logic        sclk_q_r, sclk_q_nxt;
  logic        sck_fall, sync_n;
  logic [23:0] shift_r, shift_nxt;
  logic [4:0]  cnt_r, cnt_nxt;
  logic        over_r, over_nxt;
  logic        in_frame_r, in_frame_nxt;
  logic [15:0] stage_r [4];
  logic [15:0] stage_nxt [4];
  logic [15:0] out_r [4];
  logic [15:0] out_nxt [4];
  logic [2:0]  span_r [4];
  logic [2:0]  span_nxt [4];
  logic [3:0]  ctrl_r, ctrl_nxt;
  logic [23:0] rd_r, rd_nxt;
  logic [15:0] rd_word;
  logic        upd_r, upd_nxt;
  logic        sdo_r, sdo_nxt;
  logic        oe_r, oe_nxt;
  logic        done;

  qdc_sync u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  ({i_sclk, i_sync_n, i_serial_in_line}),
    .o_sync   (pins)
  );

  // Mask unused low bits by resolution
  function automatic logic [15:0] res_mask(input logic [15:0] d);
    logic [15:0] m;
    m = d;
    if (RES_BITS == 14)
      m[1:0] = 2'h0;
    else if (RES_BITS == 12)
      m[3:0] = 4'h0;
    return m;
  endfunction : res_mask

  // Channel hit: own index or the all-channels code
  function automatic logic ch_hit(input logic [2:0] a, input int i);
    return (a == qdc_pkg::CH_ALL) || (a == 3'(i));
  endfunction : ch_hit

  // Clear code depends on span polarity and clear select
  function automatic logic [15:0] clr_code(input logic [2:0] sp,
                                           input logic sel);
    logic bip;
    bip = (sp >= qdc_pkg::SPAN_B5);
    if (!sel)
      return bip ? qdc_pkg::CODE_MID : qdc_pkg::CODE_ZERO_UNI;
    return bip ? qdc_pkg::CODE_NEG_FS : qdc_pkg::CODE_MID;
  endfunction : clr_code

  assign sync_n   = pins[1];
  assign sck_fall = sclk_q_r & ~pins[2];
  // Frame acts at the rising frame line, after exactly 24 bits
  assign done = in_frame_r & sync_n & (cnt_r == 5'h0) & over_r;

  // Readback word for addressed register
  always_comb
  begin
    logic [1:0] ch;
    ch = shift_r[17:16];
    rd_word = 16'h0000;
    unique case (shift_r[qdc_pkg::POS_SEL_HI:qdc_pkg::POS_SEL_LO])
      qdc_pkg::SEL_CODE: rd_word = stage_r[ch];
      qdc_pkg::SEL_SPAN: rd_word = {13'h0, span_r[ch]};
      qdc_pkg::SEL_CTRL: rd_word = {12'h0, ctrl_r};
      default:           rd_word = 16'h0000;
    endcase
  end

  // Shift, count and command decode
  always_comb
  begin
    sclk_q_nxt   = pins[2];
    shift_nxt    = shift_r;
    cnt_nxt      = cnt_r;
    over_nxt     = over_r;
    in_frame_nxt = in_frame_r;
    ctrl_nxt     = ctrl_r;
    rd_nxt       = rd_r;
    upd_nxt      = 1'b0;
    sdo_nxt      = sdo_r;
    for (int i = 0; i < qdc_pkg::NUM_CH; i++)
    begin
      stage_nxt[i] = stage_r[i];
      out_nxt[i]   = out_r[i];
      span_nxt[i]  = span_r[i];
    end
    if (!sync_n && !in_frame_r)
    begin
      in_frame_nxt = 1'b1;
      cnt_nxt      = 5'h0;
      over_nxt     = 1'b0;
    end
    else if (in_frame_r && !sync_n && sck_fall)
    begin
      shift_nxt = {shift_r[22:0], pins[0]};
      sdo_nxt   = rd_r[23];
      rd_nxt    = {rd_r[22:0], 1'b0};
      if (over_r)
        cnt_nxt = 5'h1; // Too many bits: mark count bad
      else if (cnt_r == qdc_pkg::CNT_LAST)
      begin
        cnt_nxt  = 5'h0;
        over_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 5'h1;
    end
    if (sync_n && in_frame_r)
      in_frame_nxt = 1'b0;
    if (done && shift_r[qdc_pkg::POS_RW])
      rd_nxt = {8'h0, rd_word}; // Read: next frame shifts it out
    if (done && !shift_r[qdc_pkg::POS_RW])
    begin
      unique case (shift_r[qdc_pkg::POS_SEL_HI:qdc_pkg::POS_SEL_LO])
        qdc_pkg::SEL_CODE:
          for (int i = 0; i < qdc_pkg::NUM_CH; i++)
            if (ch_hit(shift_r[qdc_pkg::POS_CH_HI:qdc_pkg::POS_CH_LO], i))
              stage_nxt[i] = res_mask(shift_r[15:0]);
        qdc_pkg::SEL_SPAN:
          for (int i = 0; i < qdc_pkg::NUM_CH; i++)
            if (ch_hit(shift_r[qdc_pkg::POS_CH_HI:qdc_pkg::POS_CH_LO], i))
              span_nxt[i] = shift_r[2:0];
        qdc_pkg::SEL_CTRL:
          unique case (shift_r[qdc_pkg::POS_CH_HI:qdc_pkg::POS_CH_LO])
            qdc_pkg::FN_CFG: ctrl_nxt = shift_r[3:0];
            qdc_pkg::FN_CLEAR:
            begin
              for (int i = 0; i < qdc_pkg::NUM_CH; i++)
                out_nxt[i] = clr_code(span_r[i],
                                      ctrl_r[qdc_pkg::POS_CLRSEL]);
              upd_nxt = 1'b1;
            end
            qdc_pkg::FN_LOAD:
            begin
              for (int i = 0; i < qdc_pkg::NUM_CH; i++)
                out_nxt[i] = stage_r[i];
              upd_nxt = 1'b1;
            end
            default: ; // No-op and unused functions
          endcase
        default: ; // Power control lies outside this block
      endcase
    end
    oe_nxt = in_frame_r & ~ctrl_r[qdc_pkg::POS_SDO_OFF];
  end

  // Register all state; reset to documented defaults
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      sclk_q_r   <= qdc_pkg::PIN_IDLE[2]; // Idle level: no false edge
      shift_r    <= 24'h000000;
      cnt_r      <= 5'h0;
      over_r     <= 1'b0;
      in_frame_r <= 1'b0;
      ctrl_r     <= qdc_pkg::CTRL_RESET;
      rd_r       <= 24'h000000;
      upd_r      <= 1'b0;
      sdo_r      <= 1'b0;
      oe_r       <= 1'b0;
      for (int i = 0; i < qdc_pkg::NUM_CH; i++)
      begin
        stage_r[i] <= qdc_pkg::CODE_RESET;
        out_r[i]   <= qdc_pkg::CODE_RESET;
        span_r[i]  <= qdc_pkg::SPAN_RESET;
      end
    end
    else
    begin
      sclk_q_r   <= sclk_q_nxt;
      shift_r    <= shift_nxt;
      cnt_r      <= cnt_nxt;
      over_r     <= over_nxt;
      in_frame_r <= in_frame_nxt;
      ctrl_r     <= ctrl_nxt;
      rd_r       <= rd_nxt;
      upd_r      <= upd_nxt;
      sdo_r      <= sdo_nxt;
      oe_r       <= oe_nxt;
      for (int i = 0; i < qdc_pkg::NUM_CH; i++)
      begin
        stage_r[i] <= stage_nxt[i];
        out_r[i]   <= out_nxt[i];
        span_r[i]  <= span_nxt[i];
      end
    end
  end

  assign o_dac_codes  = {out_r[3], out_r[2], out_r[1], out_r[0]};
  assign o_spans      = {span_r[3], span_r[2], span_r[1], span_r[0]};
  assign o_thermal_en = ctrl_r[qdc_pkg::POS_TSD];
  assign o_clamp_en   = ctrl_r[qdc_pkg::POS_CLAMP];
  assign o_update     = upd_r;
  assign o_sdo        = sdo_r;
  assign o_sdo_oe     = oe_r;

  // Load frame copies staged code a cycle later
  property p_load;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && !shift_r[23] && shift_r[21:19] == 3'h3 &&
     shift_r[18:16] == 3'h5) |=> (out_r[0] == $past(stage_r[0]) && upd_r);
  endproperty
  a_load: assert property (p_load) else $error("load failed");

  property p_bad_len;
    @(posedge i_mclk) disable iff (!i_resetn)
    (in_frame_r && sync_n && !over_r) |=> $stable(ctrl_r);
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("short frame acted");

  property p_sdo_off;
    @(posedge i_mclk) disable iff (!i_resetn)
    ctrl_r[0] |=> !o_sdo_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven");

  property p_span;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && !shift_r[23] && shift_r[21:16] == 6'h0C)
      |=> span_r[0] == $past(shift_r[2:0]);
  endproperty
  a_span: assert property (p_span) else $error("span not stored");

  property p_upd_cause;
    @(posedge i_mclk) disable iff (!i_resetn)
    upd_r |-> $past(done && !shift_r[23] && shift_r[21:19] == 3'h3);
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("stray update");

  property p_code_all;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && !shift_r[23] && shift_r[21:16] == 6'h04)
      |=> stage_r[3] == res_mask($past(shift_r[15:0]));
  endproperty
  a_code_all: assert property (p_code_all) else $error("all-ch write");

  property p_read_nochg;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && shift_r[23]) |=> ($stable(ctrl_r) && $stable(span_r[0]));
  endproperty
  a_read_nochg: assert property (p_read_nochg) else $error("read wrote");

  property p_nop;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && shift_r[21:16] == 6'h18) |=> ($stable(ctrl_r) && !upd_r);
  endproperty
  a_nop: assert property (p_nop) else $error("nop acted");

  // Clear with select 0 on a unipolar span must land on zero volts
  property p_clear;
    @(posedge i_mclk) disable iff (!i_resetn)
    (done && !shift_r[23] && shift_r[21:16] == 6'h1C) |=>
      (upd_r && ($past(ctrl_r[1]) || $past(span_r[2]) >= 3'h3 ||
                 out_r[2] == qdc_pkg::CODE_ZERO_UNI));
  endproperty
  a_clear: assert property (p_clear) else $error("clear code wrong");
endmodule : qdc_decoder
`default_nettype wire

// ==== test/qdc_host_model.sv ====
// Host serial port model: frames, shifts and captures readback
`default_nettype none
module qdc_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_sync_n,
  output logic      o_serial_in_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link idles with clock high and frame line released
  initial
  begin
    o_sclk   = 1'b1;
    o_sync_n = 1'b1;
    o_serial_in_line   = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : hw

  // Eight clocks per bit keeps the link well inside the sampling limit
  task automatic xfer(input logic [23:0] w, input int n,
                      output logic [23:0] rd, output logic oe);
    rd = 24'h000000;
    oe = 1'b0;
    hw(1);
    o_sync_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_serial_in_line = (i < 24) ? w[23 - i] : 1'b0; // Flag first
      hw(4);
      o_sclk = 1'b0;
      hw(4);
      // Device moves its output after each fall, so sample just before rise
      rd = {rd[22:0], i_sdo};
      oe = oe | (i_sdo_oe === 1'b1);
      o_sclk = 1'b1;
    end
    hw(4);
    o_sync_n = 1'b1; // Window closes after n bits
    o_serial_in_line = ~o_serial_in_line; // Released line must not keep the last bit
    hw(8);
  endtask : xfer
endmodule : qdc_host_model
`default_nettype wire

// ==== test/qdc_decoder_tb_top.sv ====
// Self-checking bench for the serial command decoder
`default_nettype none
module qdc_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          RES  = 14;
  localparam logic [15:0] MASK = 16'hFFFF << (16 - RES);
  logic        mclk, resetn, sclk, sync_n, serial_in_line, serial_out_line, sdo_oe;
  logic        therm, clamp, upd, oe;
  logic [63:0] codes;
  logic [11:0] spans;
  logic [23:0] rd;
  logic [15:0] d;
  logic [15:0] stg [4];
  logic [15:0] oute [4];
  logic [2:0]  sp [4];
  int          bad_count, checks, upd_n, upd_e, seed;

  qdc_decoder #(.RES_BITS(RES)) dut (.i_mclk(mclk), .i_resetn(resetn),
    .i_sclk(sclk), .i_sync_n(sync_n), .i_serial_in_line(serial_in_line), .o_sdo(serial_out_line),
    .o_sdo_oe(sdo_oe), .o_dac_codes(codes), .o_spans(spans),
    .o_thermal_en(therm), .o_clamp_en(clamp), .o_update(upd));
  qdc_host_model host (.i_mclk(mclk), .i_sdo(serial_out_line), .i_sdo_oe(sdo_oe),
    .o_sclk(sclk), .o_sync_n(sync_n), .o_serial_in_line(serial_in_line));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Tally update strobes; a stuck or doubled pulse shows in the count
  always @(posedge mclk)
    if (upd === 1'b1)
      upd_n++;

  function automatic logic [23:0] fr(logic rw, logic [2:0] sel, ch,
                                     logic [15:0] dt);
    return {rw, 1'b0, sel, ch, dt}; // Field order, zero bit
  endfunction : fr

  // Clear code follows span polarity and clear select
  function automatic logic [15:0] clr(logic [2:0] s, logic cs);
    if (s >= qdc_pkg::SPAN_B5)
      return cs ? qdc_pkg::CODE_NEG_FS : qdc_pkg::CODE_MID;
    return cs ? qdc_pkg::CODE_MID : qdc_pkg::CODE_ZERO_UNI;
  endfunction : clr

  task automatic chk(logic [63:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic send(logic [23:0] f, int n = 24);
    host.xfer(f, n, rd, oe);
    repeat (4) @(negedge mclk);
  endtask : send

  task automatic chk_all(logic th, cl);
    chk(codes, {oute[3], oute[2], oute[1], oute[0]}); // Codes
    chk(spans, {sp[3], sp[2], sp[1], sp[0]}); // Spans
    chk({therm, clamp}, {th, cl}); // Control bits
    chk(upd_n, upd_e); // Strobes
  endtask : chk_all

  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard well beyond the test's run time
  initial
  begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    seed = 32'hc6f1;
    resetn = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      stg[i] = 16'h0000;
      oute[i] = 16'h0000;
      sp[i] = 3'h1;
    end
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    chk(spans, 12'h000); // Spans clear on reset
    chk(sdo_oe, 1'b0); // Idle output off
    send(fr(1'b0, qdc_pkg::SEL_SPAN, qdc_pkg::CH_ALL, 16'hFFF9));
    chk_all(1'b0, 1'b1); // Defaults and broadcast
    // Every span code once, junk in the ignored high bits
    for (int k = 0; k < 6; k++)
    begin
      d = 16'($random(seed));
      d[2:0] = k[2:0];
      sp[k % 4] = k[2:0];
      send(fr(1'b0, qdc_pkg::SEL_SPAN, 3'(k % 4), d)); // Span
      chk_all(1'b0, 1'b1);
    end
    for (int i = 0; i < 4; i++)
    begin
      stg[i] = 16'($random(seed));
      send(fr(1'b0, qdc_pkg::SEL_CODE, 3'(i), stg[i])); // Stage
    end
    // Short, long, power, read frames must leave all state alone
    send(fr(1'b0, qdc_pkg::SEL_CODE, 3'h0, 16'h1234), 23);
    send(fr(1'b0, qdc_pkg::SEL_CODE, 3'h0, 16'h4321), 25);
    send(fr(1'b0, qdc_pkg::SEL_POWER, 3'h0, 16'hFFFF)); // Ignored
    send(fr(1'b1, qdc_pkg::SEL_SPAN, 3'h2, 16'h0007)); // Read
    chk_all(1'b0, 1'b1); // Staged only
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_LOAD, 16'hFFFF));
    chk(rd, {21'h000000, sp[2]}); // Span readback
    upd_e++;
    for (int i = 0; i < 4; i++)
      oute[i] = stg[i] & MASK;
    chk_all(1'b0, 1'b1); // Loaded, low bits masked
    send(fr(1'b1, qdc_pkg::SEL_CODE, 3'h1, 16'($random(seed))));
    chk(oe, 1'b1); // Output driven in frame
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_NOP, 16'hFFFF));
    chk(rd, {8'h00, stg[1] & MASK}); // Readback word
    chk_all(1'b0, 1'b1); // No-op changes nothing
    d = 16'($random(seed));
    send(fr(1'b0, qdc_pkg::SEL_CODE, qdc_pkg::CH_ALL, d)); // All
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_LOAD, 16'h0000));
    upd_e++;
    for (int i = 0; i < 4; i++)
    begin
      stg[i] = d;
      oute[i] = d & MASK;
    end
    chk_all(1'b0, 1'b1); // Broadcast code loaded
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_CFG, 16'hFFF9));
    chk_all(1'b1, 1'b0); // Thermal on, clamp off
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_NOP, 16'h0000));
    chk(oe, 1'b0); // Output disabled
    // Both clear selects over mixed unipolar and bipolar spans
    for (int c = 0; c < 2; c++)
    begin
      d = {12'h000, 2'b01, c[0], 1'b0};
      send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_CFG, d));
      send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_CLEAR, 16'hFFFF));
      upd_e++;
      for (int i = 0; i < 4; i++)
        oute[i] = clr(sp[i], c[0]);
      chk_all(1'b0, 1'b1); // Clear codes
    end
    send(fr(1'b0, qdc_pkg::SEL_CTRL, qdc_pkg::FN_LOAD, 16'h5A5A));
    upd_e++;
    for (int i = 0; i < 4; i++)
      oute[i] = stg[i] & MASK;
    chk_all(1'b0, 1'b1); // Staged codes survive clear
    tally_and_finish();
  end
endmodule : qdc_decoder_tb_top
`default_nettype wire
